// ==== bench/otp_ctrl_sva.sv ====
`timescale 1ns/1ps
`include "otp_ctrl_map.vh"
// ------------------------
// Port checker
// ------------------------
module otp_ctrl_sva (
  // Clock and reset
  input logic sys_clk,
  input logic rst,
  // Register and memory ports
  input logic [7:0] reg_addr,
  input logic [31:0] reg_wdata,
  input logic reg_wr,
  input logic reg_rd,
  input logic [31:0] reg_rdata_ff,
  input logic mem_rd,
  input logic mem_rvalid_ff,
  // Array side
  input logic cell_ldo_en_ff,
  input logic cell_cs_ff,
  input logic [2:0] cell_mode_ff,
  input logic cell_rd_ff,
  input logic cell_cell_write_mode_ff,
  input logic [5:0] cell_bit_ff,
  // Bus master
  input logic hready,
  input logic hbusreq_ff,
  input logic hlock_ff,
  input logic [1:0] htrans_ff,
  input logic [31:0] haddr_ff,
  input logic [2:0] hburst_ff,
  input logic hwrite_ff,
  input logic [2:0] hsize_ff
);
  logic [31:0] pword_ff;
  logic [7:0] hi_ff;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pword_ff <= 32'hFFFFFFFF;
      hi_ff <= 8'h00;
    end else begin
      if (reg_wr && reg_addr == `REG_PWORD) begin
        pword_ff <= reg_wdata;
      end
      hi_ff <= cell_cell_write_mode_ff ? hi_ff + 8'h01 : 8'h00;
    end
  end

  sequence s_fetch;
    cell_rd_ff ##2 mem_rvalid_ff;
  endsequence

  AST_FETCH: assert property (mem_rd && cell_mode_ff == `MODE_READ |-> ##1 s_fetch)
    else $error("memory read not fetched");
  AST_STANDBY_MODE: assert property (cell_mode_ff == `MODE_STANDBY_MODE |=> !cell_cs_ff && cell_ldo_en_ff)
    else $error("standby levels wrong");
  AST_DEEP: assert property (cell_mode_ff == `MODE_DEEP |=> !cell_ldo_en_ff && !cell_cs_ff)
    else $error("deep standby levels wrong");
  AST_VIA_STANDBY_MODE: assert property ($changed(cell_mode_ff) && $past(cell_mode_ff) != `MODE_STANDBY_MODE
    |-> cell_mode_ff == `MODE_STANDBY_MODE) else $error("mode change skipped standby");
  AST_ZERO_ONLY: assert property ($rose(cell_cell_write_mode_ff) && cell_bit_ff < 6'd32
    |-> !pword_ff[cell_bit_ff[4:0]]) else $error("pulse on a one bit");
  AST_PULSE: assert property ($fell(cell_cell_write_mode_ff) |-> hi_ff == 8'd100)
    else $error("program pulse length wrong");
  AST_REG_QUIET: assert property (!$past(reg_rd) |-> reg_rdata_ff == 32'h0)
    else $error("read data outside answer cycle");
  AST_BURST: assert property (htrans_ff == `HTRANS_NONSEQ |-> hsize_ff == `HSIZE_WORD &&
    hburst_ff inside {`HBURST_SINGLE, `HBURST_INCR, `HBURST_INCR4, `HBURST_INCR8})
    else $error("burst kind wrong");
  AST_SEQ: assert property (htrans_ff == `HTRANS_SEQ && $past(hready)
    |-> haddr_ff == $past(haddr_ff) + 32'h4) else $error("burst address step wrong");
  AST_LOCK: assert property (htrans_ff != `HTRANS_IDLE && hwrite_ff |-> hlock_ff && hbusreq_ff)
    else $error("mirror write without lock");
endmodule // otp_ctrl_sva

bind otp_array_controller otp_ctrl_sva chk (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata_ff, .mem_rd, .mem_rvalid_ff, .cell_ldo_en_ff, .cell_cs_ff, .cell_mode_ff, .cell_rd_ff,
  .cell_cell_write_mode_ff, .cell_bit_ff, .hready, .hbusreq_ff, .hlock_ff, .htrans_ff, .haddr_ff, .hburst_ff,
  .hwrite_ff, .hsize_ff);

// ==== bench/otp_far_model.sv ====
`timescale 1ns/1ps
// ------------------------
// Array cell and bus slave
// ------------------------
module otp_far_model (
  // Clock and pacing
  input logic sys_clk,
  input logic slow,
  // Array side
  input logic [12:0] cell_addr_ff,
  input logic cell_rd_ff,
  input logic cell_cell_write_mode_ff,
  input logic [5:0] cell_bit_ff,
  output logic [31:0] cell_rdata,
  // Bus side
  input logic hbusreq_ff,
  input logic [1:0] htrans_ff,
  input logic [31:0] haddr_ff,
  input logic hwrite_ff,
  input logic [31:0] hwdata_ff,
  output logic hgrant,
  output logic hready,
  output logic [31:0] hrdata
);
  logic [31:0] arr [0:8191];
  logic [31:0] ram [0:63];
  logic [31:0] q_ff;
  logic v_ff, aph_ff, aw_ff;
  logic [5:0] aa_ff;
  logic [3:0] cnt_ff;

  initial begin
    for (int i = 0; i < 8192; i++) arr[i] = 32'hFFFFFFFF;
    for (int i = 0; i < 64; i++) ram[i] = 32'h0;
    {q_ff, v_ff, aph_ff, aw_ff, aa_ff, cnt_ff, hgrant} = '0;
  end

  always @(posedge sys_clk) begin
    cnt_ff <= cnt_ff + 4'h1;
    v_ff <= cell_rd_ff;
    hgrant <= hbusreq_ff;
    if (cell_rd_ff) q_ff <= arr[cell_addr_ff];
    else if (v_ff) q_ff <= ~q_ff;
    if (cell_cell_write_mode_ff && cell_bit_ff < 6'd32) arr[cell_addr_ff][cell_bit_ff[4:0]] <= 1'b0;
    if (hready) begin
      aph_ff <= htrans_ff[1];
      aw_ff <= hwrite_ff;
      aa_ff <= haddr_ff[7:2];
      if (aph_ff && aw_ff) ram[aa_ff] <= hwdata_ff;
    end
  end

  assign cell_rdata = q_ff;
  assign hready = !(slow && cnt_ff[0]);
  assign hrdata = (aph_ff && !aw_ff) ? ram[aa_ff] : {8{cnt_ff}};
endmodule // otp_far_model

// ==== bench/tb_top.sv ====
`timescale 1ns/1ps
`include "otp_ctrl_map.vh"
// ------------------------
// Testbench
// ------------------------
module tb_top;
  logic sys_clk, rst, reg_wr, reg_rd, mem_rd, mem_wr, slow, pmu_mirror_req, pv;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata_ff, mem_rdata_ff, cell_rdata, hrdata, haddr_ff, hwdata_ff, v;
  logic [12:0] mem_addr, cell_addr_ff;
  logic mem_rvalid_ff, cell_pwr_ff, cell_ldo_en_ff, cell_cs_ff, cell_rd_ff, cell_cell_write_mode_ff;
  logic hgrant, hready, hbusreq_ff, hlock_ff, hwrite_ff, pmu_mirror_ack_ff;
  logic [2:0] cell_mode_ff, hburst_ff, hsize_ff;
  logic [5:0] cell_bit_ff;
  logic [1:0] htrans_ff;
  logic [2:0] bq [$];
  int miscompares, n_compared, nd, nc;
  localparam logic [31:0] pw = 32'hA5A50F0F;
  localparam logic [12:0] pa = 13'h1ABC;
  localparam logic [31:0] ones = 32'hFFFFFFFF;

  otp_array_controller dut (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_ff,
    .mem_addr, .mem_rd, .mem_wr, .mem_rdata_ff, .mem_rvalid_ff, .cell_rdata, .cell_pwr_ff,
    .cell_ldo_en_ff, .cell_cs_ff, .cell_mode_ff, .cell_addr_ff, .cell_rd_ff, .cell_cell_write_mode_ff, .cell_bit_ff,
    .hgrant, .hready, .hrdata, .hbusreq_ff, .hlock_ff, .htrans_ff, .haddr_ff, .hburst_ff, .hwrite_ff,
    .hsize_ff, .hwdata_ff, .pmu_mirror_req, .pmu_mirror_ack_ff);
  otp_far_model far (.sys_clk, .slow, .cell_addr_ff, .cell_rd_ff, .cell_cell_write_mode_ff, .cell_bit_ff,
    .cell_rdata, .hbusreq_ff, .htrans_ff, .haddr_ff, .hwrite_ff, .hwdata_ff, .hgrant, .hready, .hrdata);

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    pv <= cell_cell_write_mode_ff;
    if (cell_cell_write_mode_ff && !pv) begin
      if (cell_bit_ff < 6'd32) nd++;
      else nc++;
    end
    if (htrans_ff == `HTRANS_NONSEQ && hready) bq.push_back(hburst_ff);
  end

  task end_sim;
    $display("compared %0d, wrong %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task fail;
    miscompares++;
    end_sim;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task rdv(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata_ff;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    rdv(a, v);
    chk(v, e);
  endtask
  task waitbit(input int b, input int n);
    v = 32'h0;
    for (int i = 0; i < n && v[b] !== 1'b1; i++) rdv(`REG_STAT, v);
    if (v[b] !== 1'b1) fail;
  endtask
  task setmode(input logic [2:0] m);
    wr(`REG_MODE, {29'h0, m});
    waitbit(`STAT_MODE_READY, 60);
  endtask
  task mrd(input logic [12:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    mem_rd <= 1'b1;
    mem_addr <= a;
    @(posedge sys_clk);
    mem_rd <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1 chk({31'h0, mem_rvalid_ff}, 32'h1);
    chk(mem_rdata_ff, e);
  endtask

  initial begin
    {rst, reg_wr, reg_rd, mem_rd, mem_wr, slow, pmu_mirror_req, pv} = 8'h80;
    {reg_addr, reg_wdata, mem_addr} = '0;
    {miscompares, n_compared, nd, nc} = '0;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    rd(`REG_STAT, 32'h5);
    rd(`REG_MODE, 32'h0);
    rd(8'h30, 32'h0);
    chk({30'h0, cell_pwr_ff, cell_ldo_en_ff}, 32'h2);
    mrd(13'h0, 32'h0);
    rd(`REG_STAT, 32'h15);
    wr(`REG_STAT, 32'h10);
    rd(`REG_STAT, 32'h5);
    for (int m = 4; m > 0; m--) begin
      setmode(m[2:0]);
      rd(`REG_STAT, {21'h0, m[2:0], 8'h05});
      chk({31'h0, cell_cs_ff}, {31'h0, m != 1});
    end
    chk({31'h0, cell_ldo_en_ff}, 32'h1);
    setmode(`MODE_READ);
    mrd(pa, ones);
    @(posedge sys_clk);
    mem_wr <= 1'b1;
    @(posedge sys_clk);
    mem_wr <= 1'b0;
    rd(`REG_STAT, 32'h215);
    wr(`REG_STAT, 32'h10);
    setmode(`MODE_CELL_WRITE_MODE);
    wr(`REG_PWORD, pw);
    wr(`REG_PADDR, {19'h0, pa});
    wr(`REG_PADDR, 32'h2);
    rd(`REG_STAT, 32'h301);
    waitbit(`STAT_CELL_WRITE_MODE_DONE, 2000);
    chk(nd, 32 - $countones(pw));
    chk(nc, 6);
    rd(`REG_STAT, 32'h307);
    setmode(`MODE_VFY);
    mrd(pa, pw);
    mrd(13'h2, ones);
    setmode(`MODE_INIT);
    mrd(pa + 13'h1, ones);
    setmode(`MODE_AUTO);
    slow <= 1'b1;
    wr(`REG_DMA_ADDR, 32'h0);
    wr(`REG_DMA_NWORDS, 32'h9);
    wr(`REG_CELL_START, {19'h0, pa});
    pmu_mirror_req <= 1'b1;
    for (int i = 0; i < 1000 && pmu_mirror_ack_ff !== 1'b1; i++) @(posedge sys_clk);
    if (pmu_mirror_ack_ff !== 1'b1) fail;
    pmu_mirror_req <= 1'b0;
    slow <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk(far.ram[0], pw);
    chk(far.ram[9], ones);
    chk(far.ram[10], 32'h0);
    chk({29'h0, bq[0]}, {29'h0, `HBURST_INCR8});
    chk({29'h0, bq[1]}, {29'h0, `HBURST_INCR});
    wr(`REG_DMA_ADDR, 32'h0);
    wr(`REG_DMA_NWORDS, 32'h3);
    wr(`REG_DMA_CTRL, 32'h3);
    v = 32'h0;
    for (int i = 0; i < 100 && v[15:12] !== 4'h4; i++) rdv(`REG_STAT, v);
    if (v[15:12] !== 4'h4) fail;
    for (int i = 0; i < 4; i++) rd(`REG_FIFO_DATA, i == 0 ? pw : ones);
    chk({29'h0, bq[2]}, {29'h0, `HBURST_INCR4});
    rd(`REG_DMA_CTRL, 32'h2);
    setmode(3'h7);
    rd(`REG_MODE, 32'h1);
    setmode(`MODE_DEEP);
    rd(`REG_STAT, 32'h7);
    chk({31'h0, cell_ldo_en_ff}, 32'h0);
    end_sim;
  end
endmodule // tb_top

// ==== core/otp_array_controller.v ====
// Notes on behaviour
// - Controller times every array access, full words.
// - One-word program buffer, no burst programming.
// - Blank word reads ones; program whole word.
// - 8192 words, 32 data, 6 hidden check.
// - Array handles check bits by itself.
// - DMA with eight-word FIFO, reads and writes.
// - INCR8, INCR4, INCR, SINGLE; reads in fours.
// - Register region read/write, memory region read-only.
// - Deep standby: supplies on, regulator off.
// - Standby: chip select off, regulator on.
// - Memory-region read becomes array fetch sequence.
// - Pulse only zero bits, plus six check pulses.
// - Buffer is data word and 13-bit address.
// - New request only after previous served, flagged.
// - Verify mode gives margin reads via memory.
// - Initial mode gives margin reads for blank check.
// - Auto mode mirrors array into RAM by DMA.
// - Every mode change passes through standby.
// - Mirroring locks bus, started by PMU handshake.
// - Mode codes 1 standby,2 read,3 program,4 verify.
// - Mode-ready flag rises once new mode active.
// - Data then address; done flag when finished.
//
// Decided for this implementation: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`include "otp_ctrl_map.vh"

module otp_array_controller (
  // Clock and reset
  input wire sys_clk,
  input wire rst,
  // Register port
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata_ff,
  // Memory region port
  input wire [12:0] mem_addr,
  input wire mem_rd,
  input wire mem_wr,
  output reg [31:0] mem_rdata_ff,
  output reg mem_rvalid_ff,
  // Array macro
  input wire [31:0] cell_rdata,
  output reg cell_pwr_ff,
  output reg cell_ldo_en_ff,
  output reg cell_cs_ff,
  output reg [2:0] cell_mode_ff,
  output reg [12:0] cell_addr_ff,
  output reg cell_rd_ff,
  output reg cell_cell_write_mode_ff,
  output reg [5:0] cell_bit_ff,
  // Bus master
  input wire hgrant,
  input wire hready,
  input wire [31:0] hrdata,
  output reg hbusreq_ff,
  output reg hlock_ff,
  output reg [1:0] htrans_ff,
  output reg [31:0] haddr_ff,
  output reg [2:0] hburst_ff,
  output reg hwrite_ff,
  output reg [2:0] hsize_ff,
  output reg [31:0] hwdata_ff,
  // Power manager handshake
  input wire pmu_mirror_req,
  output reg pmu_mirror_ack_ff
);

  // ----------------------------------------
  // Constants
  // ----------------------------------------
  localparam integer STANDBY_MODE_INT = `STANDBY_MODE_CYC;
  localparam integer ENTER_INT = `ENTER_CYC;
  localparam integer PULSE_INT = `PULSE_CYC;
  localparam [7:0] STANDBY_MODE_CYC = STANDBY_MODE_INT[7:0];
  localparam [7:0] ENTER_CYC = ENTER_INT[7:0];
  localparam [7:0] PULSE_CYC = PULSE_INT[7:0];
  localparam [1:0] MS_READY = 2'd0;
  localparam [1:0] MS_STANDBY_MODE = 2'd1;
  localparam [1:0] MS_ENTER = 2'd2;
  localparam [2:0] DS_IDLE = 3'd0;
  localparam [2:0] DS_FILL = 3'd1;
  localparam [2:0] DS_REQ = 3'd2;
  localparam [2:0] DS_BURST = 3'd3;
  localparam [2:0] DS_DRAIN = 3'd4;

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function [3:0] burst_len;
    input [13:0] rem;
    input rd;
    begin
      if (rd) begin
        burst_len = (rem >= 14'd4) ? 4'd4 : rem[3:0];
      end else begin
        burst_len = (rem >= 14'd8) ? 4'd8 : rem[3:0];
      end
    end
  endfunction

  function [2:0] burst_code;
    input [3:0] len;
    begin
      case (len)
        4'd8: burst_code = `HBURST_INCR8;
        4'd4: burst_code = `HBURST_INCR4;
        4'd1: burst_code = `HBURST_SINGLE;
        default: burst_code = `HBURST_INCR;
      endcase
    end
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  reg [1:0] ms_ff;
  reg [2:0] tgt_ff;
  reg [7:0] mcnt_ff;
  reg mode_ready_ff;
  reg [31:0] pword_ff;
  reg [12:0] paddr_ff;
  reg program_request_buffer_full_ff;
  reg cell_write_mode_done_ff;
  reg [5:0] pidx_ff;
  reg [7:0] pcnt_ff;
  reg mem_p1_ff;
  reg mem_p2_ff;
  reg mem_bad1_ff;
  reg mem_bad2_ff;
  reg mem_err_ff;
  reg [2:0] ds_ff;
  reg [31:0] dma_addr_ff;
  reg [12:0] nwords_ff;
  reg [12:0] cstart_ff;
  reg dir_rd_ff;
  reg [13:0] rem_ff;
  reg [3:0] blen_ff;
  reg [3:0] issued_ff;
  reg [3:0] beats_ff;
  reg [12:0] cptr_ff;
  reg dph_ff;
  reg mrd_ff;
  reg mrd_q_ff;
  reg pmu_q_ff;
  reg pmu_own_ff;
  reg [31:0] fifo_mem [0:`FIFO_DEPTH-1];
  reg [2:0] wptr_ff;
  reg [2:0] rptr_ff;
  reg [3:0] fcnt_ff;
  reg [31:0] rd_mux;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire wr_mode = reg_wr && (reg_addr == `REG_MODE);
  wire wr_stat = reg_wr && (reg_addr == `REG_STAT);
  wire wr_pword = reg_wr && (reg_addr == `REG_PWORD);
  wire wr_paddr = reg_wr && (reg_addr == `REG_PADDR);
  wire wr_ctrl = reg_wr && (reg_addr == `REG_DMA_CTRL);
  wire dma_busy = (ds_ff != DS_IDLE);
  wire cell_write_mode_ok = (cell_mode_ff == `MODE_CELL_WRITE_MODE) && mode_ready_ff;
  wire auto_ok = (cell_mode_ff == `MODE_AUTO) && mode_ready_ff;
  wire mem_ok = mode_ready_ff && ((cell_mode_ff == `MODE_READ) || (cell_mode_ff == `MODE_VFY) ||
                (cell_mode_ff == `MODE_INIT));
  wire mem_go = mem_rd && mem_ok;
  wire mirror_rd = (ds_ff == DS_FILL) && (issued_ff < blen_ff);
  wire pmu_rise = pmu_mirror_req && !pmu_q_ff;
  wire sw_start = wr_ctrl && reg_wdata[`CTRL_START];
  wire sw_rd = reg_wdata[`CTRL_DIR_RD];
  wire start_wr = !dma_busy && auto_ok && ((sw_start && !sw_rd) || pmu_rise);
  wire start_rd = !dma_busy && sw_start && sw_rd;
  wire [13:0] total = {1'b0, nwords_ff} + 14'd1;
  wire bus_adv = (ds_ff == DS_BURST) && hready;
  wire addr_live = (htrans_ff != `HTRANS_IDLE);
  wire pop_bus = bus_adv && addr_live && hwrite_ff;
  wire pop_reg = reg_rd && (reg_addr == `REG_FIFO_DATA) && dir_rd_ff && (fcnt_ff != 4'd0);
  wire push_bus = bus_adv && dph_ff && !hwrite_ff;
  wire push = push_bus || mrd_q_ff;
  wire pop = pop_bus || pop_reg;
  wire [31:0] push_data = push_bus ? hrdata : cell_rdata;
  wire [13:0] rem_next = rem_ff - {10'd0, blen_ff};

  // ----------------------------------------
  // Mode sequencer
  // ----------------------------------------
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ms_ff <= MS_READY;
      tgt_ff <= `RST_MODE;
      mcnt_ff <= 8'h00;
      mode_ready_ff <= 1'b1;
      cell_mode_ff <= `RST_MODE;
    end else begin
      case (ms_ff)
        MS_READY: begin
          if (wr_mode && !program_request_buffer_full_ff && !dma_busy) begin
            tgt_ff <= (reg_wdata[2:0] > `MODE_AUTO) ? `MODE_STANDBY_MODE : reg_wdata[2:0];
            mode_ready_ff <= 1'b0;
            cell_mode_ff <= `MODE_STANDBY_MODE;
            mcnt_ff <= STANDBY_MODE_CYC - 8'd1;
            ms_ff <= MS_STANDBY_MODE;
          end
        end
        MS_STANDBY_MODE: begin
          if (mcnt_ff != 8'h00) begin
            mcnt_ff <= mcnt_ff - 8'd1;
          end else if (tgt_ff == `MODE_STANDBY_MODE) begin
            mode_ready_ff <= 1'b1;
            ms_ff <= MS_READY;
          end else begin
            cell_mode_ff <= tgt_ff;
            mcnt_ff <= ENTER_CYC - 8'd1;
            ms_ff <= MS_ENTER;
          end
        end
        MS_ENTER: begin
          if (mcnt_ff != 8'h00) begin
            mcnt_ff <= mcnt_ff - 8'd1;
          end else begin
            mode_ready_ff <= 1'b1;
            ms_ff <= MS_READY;
          end
        end
        default: begin
          ms_ff <= MS_READY;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Array power pins
  // ----------------------------------------
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cell_pwr_ff <= 1'b0;
      cell_ldo_en_ff <= 1'b0;
      cell_cs_ff <= 1'b0;
    end else begin
      cell_pwr_ff <= 1'b1;
      cell_ldo_en_ff <= (cell_mode_ff != `MODE_DEEP);
      cell_cs_ff <= (cell_mode_ff != `MODE_DEEP) && (cell_mode_ff != `MODE_STANDBY_MODE);
    end
  end

  // ----------------------------------------
  // Program buffer and pulse engine
  // ----------------------------------------
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pword_ff <= `RST_WORD;
      paddr_ff <= 13'h0000;
      program_request_buffer_full_ff <= 1'b0;
      cell_write_mode_done_ff <= 1'b0;
      pidx_ff <= 6'h00;
      pcnt_ff <= 8'h00;
      cell_cell_write_mode_ff <= 1'b0;
      cell_bit_ff <= 6'h00;
    end else if (!program_request_buffer_full_ff) begin
      if (wr_pword) begin
        pword_ff <= reg_wdata;
      end
      if (wr_paddr && cell_write_mode_ok) begin
        paddr_ff <= reg_wdata[12:0];
        program_request_buffer_full_ff <= 1'b1;
        cell_write_mode_done_ff <= 1'b0;
        pidx_ff <= 6'h00;
      end
    end else if (pcnt_ff != 8'h00) begin
      pcnt_ff <= pcnt_ff - 8'd1;
      if (pcnt_ff == 8'd1) begin
        cell_cell_write_mode_ff <= 1'b0;
      end
    end else if (pidx_ff == `CELL_WRITE_MODE_STEPS) begin
      program_request_buffer_full_ff <= 1'b0;
      cell_write_mode_done_ff <= 1'b1;
    end else begin
      cell_bit_ff <= pidx_ff;
      if (pidx_ff[5] || !pword_ff[pidx_ff[4:0]]) begin
        cell_cell_write_mode_ff <= 1'b1;
        pcnt_ff <= PULSE_CYC;
      end
      pidx_ff <= pidx_ff + 6'd1;
    end
  end

  // ----------------------------------------
  // Array read port and memory region
  // ----------------------------------------
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cell_rd_ff <= 1'b0;
      cell_addr_ff <= 13'h0000;
      mem_p1_ff <= 1'b0;
      mem_p2_ff <= 1'b0;
      mem_bad1_ff <= 1'b0;
      mem_bad2_ff <= 1'b0;
      mem_rvalid_ff <= 1'b0;
      mem_rdata_ff <= 32'h00000000;
      mrd_ff <= 1'b0;
      mrd_q_ff <= 1'b0;
      mem_err_ff <= 1'b0;
    end else begin
      cell_rd_ff <= mem_go || mirror_rd;
      if (mem_go) begin
        cell_addr_ff <= mem_addr;
      end else if (mirror_rd) begin
        cell_addr_ff <= cptr_ff;
      end else if (program_request_buffer_full_ff) begin
        cell_addr_ff <= paddr_ff;
      end
      mrd_ff <= mirror_rd;
      mrd_q_ff <= mrd_ff;
      mem_p1_ff <= mem_rd;
      mem_bad1_ff <= mem_rd && !mem_ok;
      mem_p2_ff <= mem_p1_ff;
      mem_bad2_ff <= mem_bad1_ff;
      mem_rvalid_ff <= mem_p2_ff;
      if (mem_p2_ff) begin
        mem_rdata_ff <= mem_bad2_ff ? 32'h00000000 : cell_rdata;
      end
      if (mem_wr || (mem_rd && !mem_ok)) begin
        mem_err_ff <= 1'b1;
      end else if (wr_stat && reg_wdata[`STAT_MEM_ERR]) begin
        mem_err_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // FIFO
  // ----------------------------------------
  always @(posedge sys_clk) begin
    if (push) begin
      fifo_mem[wptr_ff] <= push_data;
    end
  end

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wptr_ff <= 3'h0;
      rptr_ff <= 3'h0;
      fcnt_ff <= 4'h0;
    end else begin
      if (push) begin
        wptr_ff <= wptr_ff + 3'd1;
      end
      if (pop) begin
        rptr_ff <= rptr_ff + 3'd1;
      end
      if (push && !pop) begin
        fcnt_ff <= fcnt_ff + 4'd1;
      end else if (pop && !push) begin
        fcnt_ff <= fcnt_ff - 4'd1;
      end
    end
  end

  // ----------------------------------------
  // DMA engine and bus master
  // ----------------------------------------
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ds_ff <= DS_IDLE;
      dma_addr_ff <= 32'h00000000;
      nwords_ff <= 13'h0000;
      cstart_ff <= 13'h0000;
      dir_rd_ff <= 1'b0;
      rem_ff <= 14'h0000;
      blen_ff <= 4'h0;
      issued_ff <= 4'h0;
      beats_ff <= 4'h0;
      cptr_ff <= 13'h0000;
      dph_ff <= 1'b0;
      pmu_q_ff <= 1'b0;
      pmu_own_ff <= 1'b0;
      pmu_mirror_ack_ff <= 1'b0;
      hbusreq_ff <= 1'b0;
      hlock_ff <= 1'b0;
      htrans_ff <= `HTRANS_IDLE;
      haddr_ff <= 32'h00000000;
      hburst_ff <= `HBURST_SINGLE;
      hwrite_ff <= 1'b0;
      hsize_ff <= `HSIZE_WORD;
      hwdata_ff <= 32'h00000000;
    end else begin
      pmu_q_ff <= pmu_mirror_req;
      if (!pmu_mirror_req) begin
        pmu_mirror_ack_ff <= 1'b0;
      end
      if (!dma_busy && reg_wr && (reg_addr == `REG_DMA_ADDR)) begin
        dma_addr_ff <= reg_wdata;
      end
      if (!dma_busy && reg_wr && (reg_addr == `REG_DMA_NWORDS)) begin
        nwords_ff <= reg_wdata[12:0];
      end
      if (!dma_busy && reg_wr && (reg_addr == `REG_CELL_START)) begin
        cstart_ff <= reg_wdata[12:0];
      end
      case (ds_ff)
        DS_IDLE: begin
          if (start_wr || start_rd) begin
            dir_rd_ff <= start_rd;
            pmu_own_ff <= start_wr && pmu_rise;
            rem_ff <= total;
            cptr_ff <= cstart_ff;
            blen_ff <= burst_len(total, start_rd);
            issued_ff <= 4'h0;
            hbusreq_ff <= start_rd;
            ds_ff <= start_rd ? DS_REQ : DS_FILL;
          end
        end
        DS_FILL: begin
          if (mirror_rd) begin
            cptr_ff <= cptr_ff + 13'd1;
            issued_ff <= issued_ff + 4'd1;
          end else if (fcnt_ff == blen_ff) begin
            hbusreq_ff <= 1'b1;
            hlock_ff <= 1'b1;
            ds_ff <= DS_REQ;
          end
        end
        DS_REQ: begin
          if (hgrant && hready) begin
            htrans_ff <= `HTRANS_NONSEQ;
            haddr_ff <= dma_addr_ff;
            hburst_ff <= burst_code(blen_ff);
            hwrite_ff <= !dir_rd_ff;
            beats_ff <= blen_ff - 4'd1;
            ds_ff <= DS_BURST;
          end
        end
        DS_BURST: begin
          if (hready) begin
            if (addr_live) begin
              dph_ff <= 1'b1;
              if (hwrite_ff) begin
                hwdata_ff <= fifo_mem[rptr_ff];
              end
              if (beats_ff != 4'h0) begin
                htrans_ff <= `HTRANS_SEQ;
                haddr_ff <= haddr_ff + 32'd4;
                beats_ff <= beats_ff - 4'd1;
              end else begin
                htrans_ff <= `HTRANS_IDLE;
              end
            end else if (dph_ff) begin
              dph_ff <= 1'b0;
              hbusreq_ff <= 1'b0;
              hlock_ff <= 1'b0;
              dma_addr_ff <= dma_addr_ff + {26'd0, blen_ff, 2'b00};
              rem_ff <= rem_next;
              blen_ff <= burst_len(rem_next, dir_rd_ff);
              issued_ff <= 4'h0;
              if (dir_rd_ff) begin
                ds_ff <= DS_DRAIN;
              end else if (rem_next == 14'h0000) begin
                pmu_mirror_ack_ff <= pmu_own_ff;
                ds_ff <= DS_IDLE;
              end else begin
                ds_ff <= DS_FILL;
              end
            end
          end
        end
        DS_DRAIN: begin
          if (fcnt_ff == 4'h0) begin
            hbusreq_ff <= (rem_ff != 14'h0000);
            ds_ff <= (rem_ff == 14'h0000) ? DS_IDLE : DS_REQ;
          end
        end
        default: begin
          ds_ff <= DS_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Register read
  // ----------------------------------------
  always @* begin
    rd_mux = 32'h00000000;
    case (reg_addr)
      `REG_MODE: rd_mux = {29'd0, tgt_ff};
      `REG_STAT: begin
        rd_mux[`STAT_MODE_READY] = mode_ready_ff;
        rd_mux[`STAT_CELL_WRITE_MODE_DONE] = cell_write_mode_done_ff;
        rd_mux[`STAT_BUF_EMPTY] = !program_request_buffer_full_ff;
        rd_mux[`STAT_DMA_BUSY] = dma_busy;
        rd_mux[`STAT_MEM_ERR] = mem_err_ff;
        rd_mux[10:8] = cell_mode_ff;
        rd_mux[15:12] = fcnt_ff;
      end
      `REG_PWORD: rd_mux = pword_ff;
      `REG_PADDR: rd_mux = {19'd0, paddr_ff};
      `REG_DMA_ADDR: rd_mux = dma_addr_ff;
      `REG_DMA_NWORDS: rd_mux = {19'd0, nwords_ff};
      `REG_DMA_CTRL: rd_mux = {30'd0, dir_rd_ff, dma_busy};
      `REG_CELL_START: rd_mux = {19'd0, cstart_ff};
      `REG_FIFO_DATA: rd_mux = (fcnt_ff != 4'h0) ? fifo_mem[rptr_ff] : 32'h00000000;
      default: rd_mux = 32'h00000000;
    endcase
  end

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reg_rdata_ff <= 32'h00000000;
    end else begin
      reg_rdata_ff <= reg_rd ? rd_mux : 32'h00000000;
    end
  end

endmodule // otp_array_controller

// ==== core/otp_ctrl_map.vh ====
`ifndef OTP_CTRL_MAP_VH
`define OTP_CTRL_MAP_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define REG_MODE 8'h00
`define REG_STAT 8'h04
`define REG_PWORD 8'h08
`define REG_PADDR 8'h0C
`define REG_DMA_ADDR 8'h10
`define REG_DMA_NWORDS 8'h14
`define REG_DMA_CTRL 8'h18
`define REG_CELL_START 8'h1C
`define REG_FIFO_DATA 8'h20

// ----------------------------------------
// Field positions
// ----------------------------------------
`define STAT_MODE_READY 0
`define STAT_CELL_WRITE_MODE_DONE 1
`define STAT_BUF_EMPTY 2
`define STAT_DMA_BUSY 3
`define STAT_MEM_ERR 4
`define CTRL_START 0
`define CTRL_DIR_RD 1

// ----------------------------------------
// Array modes
// ----------------------------------------
`define MODE_DEEP 3'h0
`define MODE_STANDBY_MODE 3'h1
`define MODE_READ 3'h2
`define MODE_CELL_WRITE_MODE 3'h3
`define MODE_VFY 3'h4
`define MODE_INIT 3'h5
`define MODE_AUTO 3'h6

// ----------------------------------------
// Reset values and sizes
// ----------------------------------------
`define RST_MODE 3'h0
`define RST_WORD 32'hFFFFFFFF
`define FIFO_DEPTH 8
`define CELL_WRITE_MODE_STEPS 6'h26

// ----------------------------------------
// Timing, clock at 50 MHz
// ----------------------------------------
`define CLK_MHZ 50
`define STANDBY_MODE_NS 1000
`define ENTER_NS 200
`define PULSE_NS 2000
`define STANDBY_MODE_CYC ((`STANDBY_MODE_NS * `CLK_MHZ + 999) / 1000)
`define ENTER_CYC ((`ENTER_NS * `CLK_MHZ + 999) / 1000)
`define PULSE_CYC ((`PULSE_NS * `CLK_MHZ + 999) / 1000)

// ----------------------------------------
// Bus encodings
// ----------------------------------------
`define HTRANS_IDLE 2'h0
`define HTRANS_NONSEQ 2'h2
`define HTRANS_SEQ 2'h3
`define HBURST_SINGLE 3'h0
`define HBURST_INCR 3'h1
`define HBURST_INCR4 3'h3
`define HBURST_INCR8 3'h5
`define HSIZE_WORD 3'h2

`endif
